//--- hdl/dac_link_host.sv
/*
 * Host end of the serial write link: sends one 24-bit word per frame.
 * Assumes a 125 MHz core clock; the serial clock is divided from it.
 */
`timescale 1ns/100ps
module dac_link_host
    import dac_link_pkg::*;
#(
    parameter int WORD_W = WORD_BITS
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Link.
    serial_link_if.host link,
    // Word request.
    input wire logic txValid,
    input wire logic [WORD_W-1:0] txData,
    output logic txReady,
    input wire logic abortReq,
    output logic txDone
);
    typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, GAP} host_e;

    typedef struct packed {
        host_e state;
        logic [TIM_W-1:0] tim;
        logic [BIT_CNT_W-1:0] bits;
        logic [WORD_W-1:0] shift;
        logic sclk;
        logic syncN;
        logic sdata;
        logic ready;
        logic done;
    } host_s;

    host_s cur_ff;
    host_s nxt_cur;
    logic onLast;

    // Every output is a register.
    assign link.frameSyncN = cur_ff.syncN;
    assign link.serialClk = cur_ff.sclk;
    assign link.serialData = cur_ff.sdata;
    assign txReady = cur_ff.ready;
    assign txDone = cur_ff.done;

    // The last bit is out once 23 rises have moved the word on.
    assign onLast = (cur_ff.bits == BIT_CNT_W'(WORD_W - 1));

    // Frame sequencer: data changes on rises, device samples on falls.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        unique case (cur_ff.state)
            IDLE: begin
                if (txValid && cur_ff.ready) begin
                    nxt_cur.syncN = 1'b0;
                    nxt_cur.shift = txData;
                    nxt_cur.sdata = txData[WORD_W-1];
                    nxt_cur.ready = 1'b0;
                    nxt_cur.bits = '0;
                    nxt_cur.tim = TIM_W'(SETUP_CYC - 1);
                    nxt_cur.state = LEAD;
                end
            end
            LEAD: begin
                if (cur_ff.tim == '0) begin
                    nxt_cur.sclk = 1'b0;
                    nxt_cur.tim = TIM_W'(HALF_CYC - 1);
                    nxt_cur.state = LOW;
                end else begin
                    nxt_cur.tim = cur_ff.tim - 1'b1;
                end
            end
            LOW: begin
                // Past the last fall the device holds the word already,
                // so an abort then would only hide a finished frame.
                if (abortReq && !onLast) begin
                    nxt_cur.syncN = 1'b1;
                    nxt_cur.sclk = 1'b1;
                    nxt_cur.tim = TIM_W'(GAP_CYC - 1);
                    nxt_cur.state = GAP;
                end else if (cur_ff.tim != '0) begin
                    nxt_cur.tim = cur_ff.tim - 1'b1;
                end else if (onLast) begin
                    nxt_cur.syncN = 1'b1;
                    nxt_cur.sclk = 1'b1;
                    nxt_cur.done = 1'b1;
                    nxt_cur.tim = TIM_W'(GAP_CYC - 1);
                    nxt_cur.state = GAP;
                end else begin
                    nxt_cur.sclk = 1'b1;
                    nxt_cur.shift = cur_ff.shift << 1;
                    nxt_cur.sdata = cur_ff.shift[WORD_W-2];
                    nxt_cur.bits = cur_ff.bits + 1'b1;
                    nxt_cur.tim = TIM_W'(HALF_CYC - 1);
                    nxt_cur.state = HIGH;
                end
            end
            HIGH: begin
                if (cur_ff.tim == '0) begin
                    nxt_cur.sclk = 1'b0;
                    nxt_cur.tim = TIM_W'(HALF_CYC - 1);
                    nxt_cur.state = LOW;
                end else begin
                    nxt_cur.tim = cur_ff.tim - 1'b1;
                end
            end
            GAP: begin
                if (cur_ff.tim == '0) begin
                    nxt_cur.ready = 1'b1;
                    nxt_cur.state = IDLE;
                end else begin
                    nxt_cur.tim = cur_ff.tim - 1'b1;
                end
            end
        endcase
    end

    // State register; ready rises only after reset releases.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '{state: GAP, tim: '0, bits: '0, shift: '0,
                sclk: SCLK_IDLE, syncN: SYNC_IDLE, sdata: 1'b0,
                ready: 1'b0, done: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end
endmodule // dac_link_host

//--- hdl/dac_link_pkg.sv
/*
 * Shared constants for the three-wire serial write link of a quad DAC:
 * word size, buffer depth and the link timing turned into core cycles.
 * Assumes the host end runs on a 125 MHz core clock.
 */
package dac_link_pkg;

    // Frame and buffer sizes.
    localparam int WORD_BITS = 24;
    localparam int BIT_CNT_W = 5;
    localparam int FIFO_DEPTH = 32;

    // Clock rates.
    localparam int CORE_PERIOD_PS = 8000;
    localparam int SCLK_MAX_MHZ = 50;

    // Link timing in nanoseconds, all least times.
    localparam int SCLK_CYCLE_NS = 20;
    localparam int SCLK_PHASE_NS = 9;
    localparam int SYNC_SETUP_NS = 13;
    localparam int SYNC_HIGH_NS = 15;

    // Rounds a least time up to whole core cycles, never below one.
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Core cycles per serial clock phase, setup and idle gap.
    localparam int HALF_CYC = (ns2cyc(SCLK_PHASE_NS) >
        ns2cyc((SCLK_CYCLE_NS + 1) / 2)) ? ns2cyc(SCLK_PHASE_NS) :
        ns2cyc((SCLK_CYCLE_NS + 1) / 2);
    localparam int SETUP_CYC = ns2cyc(SYNC_SETUP_NS);
    localparam int GAP_CYC = ns2cyc(SYNC_HIGH_NS);
    localparam int TIM_W = 4;

    // Values after reset.
    localparam logic REF_DRIVE_RST = 1'b0;
    localparam logic SYNC_IDLE = 1'b1;
    localparam logic SCLK_IDLE = 1'b1;

endpackage

//--- hdl/dac_serial_frame_receiver.sv
/*
 * Device end of the serial write link of a quad DAC. The shift logic
 * runs on the serial clock itself; completed words cross into the core
 * clock, pass a buffer and leave as one-cycle command words.
 * Assumes the host keeps the serial clock within its limits and that
 * the command decoder sits on the core clock.
 */
`timescale 1ns/100ps
module dac_serial_frame_receiver
    import dac_link_pkg::*;
#(
    parameter int WORD_W = WORD_BITS,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Core clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Link.
    serial_link_if.device link,
    // Command word output.
    input wire logic cmdReady,
    output logic [WORD_W-1:0] cmdWord,
    output logic cmdValid,
    // Status.
    output logic frameActive,
    output logic overrun,
    input wire logic clearOverrun,
    // Reference pin control.
    input wire logic selectInternalRef,
    output logic refDriveEn
);
    // Link-side frame state, cleared whenever frame sync is high.
    typedef struct packed {
        logic [BIT_CNT_W-1:0] bitCnt;
        logic [WORD_W-1:0] shift;
        logic full;
    } frame_s;

    // Link-side hand-over register, cleared by reset only.
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic toggle;
    } hold_s;

    // Core-side state.
    typedef struct packed {
        logic [2:0] tgSync;
        logic tgSeen;
        logic [2:0] fsSync;
        logic active;
        logic [WORD_W-1:0] word;
        logic valid;
        logic overrun;
        logic refDrive;
    } core_s;

    frame_s frame_ff;
    frame_s nxt_frame;
    hold_s hold_ff;
    hold_s nxt_hold;
    core_s core_ff;
    core_s nxt_core;

    logic frameClr;
    logic lastBit;
    logic [WORD_W-1:0] shiftNext;
    logic wordEvent;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoPop;
    logic [WORD_W-1:0] fifoOutData;

    // A synchronised level counts once its second and third stages agree.
    function automatic logic settled(input logic [2:0] stages);
        return stages[1] == stages[2];
    endfunction

    // A high frame sync holds the frame logic cleared, so a rise before
    // the last edge throws the partial word away without a clock edge.
    assign frameClr = rst | link.frameSyncN;

    // The new bit enters at the bottom; the first bit ends up on top.
    assign shiftNext = {frame_ff.shift[WORD_W-2:0], link.serialData};
    assign lastBit = (frame_ff.bitCnt == BIT_CNT_W'(WORD_W - 1));

    // Next frame state on a falling serial edge.
    always_comb begin
        nxt_frame = frame_ff;
        if (!frame_ff.full) begin
            nxt_frame.shift = shiftNext;
            nxt_frame.bitCnt = frame_ff.bitCnt + 1'b1;
            nxt_frame.full = lastBit;
        end
    end

    // Frame register runs on the serial clock's falling edge only, so
    // any rate the host can legally make is taken directly.
    always_ff @(negedge link.serialClk or posedge frameClr) begin
        if (frameClr) begin
            frame_ff <= '0;
        end else begin
            frame_ff <= nxt_frame;
        end
    end

    // The completed word is parked and announced by a toggle; extra
    // edges after the 24th are ignored until the frame ends.
    always_comb begin
        nxt_hold = hold_ff;
        if (!link.frameSyncN && !frame_ff.full && lastBit) begin
            nxt_hold.word = shiftNext;
            nxt_hold.toggle = ~hold_ff.toggle;
        end
    end

    // Hand-over register on the serial clock. It is cleared by reset
    // only: the toggle must survive frame ends, or a rising frame sync
    // would look like a new word to the core side.
    always_ff @(negedge link.serialClk or posedge rst) begin
        if (rst) begin
            hold_ff <= '0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    // A toggle change counts once the second and third stages agree;
    // the parked word has been stable since well before that point.
    assign wordEvent = settled(core_ff.tgSync) &&
        (core_ff.tgSync[2] != core_ff.tgSeen);
    assign fifoPop = fifoOutValid && cmdReady;

    // Core-side next state.
    always_comb begin
        nxt_core = core_ff;
        nxt_core.tgSync = {core_ff.tgSync[1:0], hold_ff.toggle};
        nxt_core.fsSync = {core_ff.fsSync[1:0], link.frameSyncN};
        if (wordEvent) begin
            nxt_core.tgSeen = core_ff.tgSync[2];
        end
        // Frame activity reported from the filtered frame sync level.
        if (settled(core_ff.fsSync)) begin
            nxt_core.active = ~core_ff.fsSync[2];
        end
        // One word per pulse towards the decoder. A pop and its pulse are
        // one cycle apart, so back-to-back pops give back-to-back
        // pulses.
        nxt_core.valid = fifoPop;
        if (fifoPop) begin
            nxt_core.word = fifoOutData;
        end
        // Lost word flag: a new loss wins over a clear.
        if (wordEvent && !fifoInReady) begin
            nxt_core.overrun = 1'b1;
        end else if (clearOverrun) begin
            nxt_core.overrun = 1'b0;
        end
        // Reference pin stays an input until the internal one is chosen.
        nxt_core.refDrive = selectInternalRef;
    end

    // Core-side register. Synchroniser stages start at the idle levels
    // of what they watch, so releasing reset shows no false edge.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_ff <= '{tgSync: '0, tgSeen: 1'b0, fsSync: {3{SYNC_IDLE}},
                active: 1'b0, word: '0, valid: 1'b0, overrun: 1'b0,
                refDrive: REF_DRIVE_RST};
        end else begin
            core_ff <= nxt_core;
        end
    end

    // Buffer between the link and the command decoder; a stalled
    // decoder fills it and further words raise the lost word flag.
    // The link cannot be held off, so the buffer's ready only decides
    // whether a finished word is kept or dropped.
    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .inValid(wordEvent),
        .inReady(fifoInReady),
        .inData(hold_ff.word),
        .outValid(fifoOutValid),
        .outReady(cmdReady),
        .outData(fifoOutData)
    );

    // All outputs come from the core register; the command word holds
    // the last popped word until the next pop.
    assign cmdWord = core_ff.word;
    assign cmdValid = core_ff.valid;
    assign frameActive = core_ff.active;
    assign overrun = core_ff.overrun;
    assign refDriveEn = core_ff.refDrive;
endmodule // dac_serial_frame_receiver

//--- hdl/serial_link_if.sv
/*
 * The three-wire serial write link between host and DAC.
 * Assumes the host drives every wire and the device only listens.
 */
`timescale 1ns/100ps
interface serial_link_if;
    logic frameSyncN;
    logic serialClk;
    logic serialData;

    // Host drives the frame.
    modport host (output frameSyncN, output serialClk, output serialData);
    // Device listens only.
    modport device (input frameSyncN, input serialClk, input serialData);
endinterface

//--- hdl/word_fifo.sv
/*
 * Synchronous first-in first-out buffer with valid and ready on both
 * sides. Assumes one clock for both sides and show-ahead read data.
 */
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } fifo_s;

    fifo_s cur_ff;
    fifo_s nxt_cur;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Full and empty come straight from the held word count.
    assign inReady = (cur_ff.count != (AW+1)'(DEPTH));
    assign outValid = (cur_ff.count != '0);
    assign outData = mem[cur_ff.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and count update.
    always_comb begin
        nxt_cur = cur_ff;
        if (push) begin
            nxt_cur.wrPtr = AW'((cur_ff.wrPtr + 1'b1) % DEPTH);
        end
        if (pop) begin
            nxt_cur.rdPtr = AW'((cur_ff.rdPtr + 1'b1) % DEPTH);
        end
        nxt_cur.count = cur_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Storage has no reset; only written words are ever read.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[cur_ff.wrPtr] <= inData;
        end
    end
endmodule // word_fifo

//--- verification/dac_serial_frame_receiver_assertions.sv
/*
 * Checker on the wires of the serial write link between the two ends.
 * Assumes the host divides the serial clock from core_clk.
 */
`timescale 1ns/100ps
module dac_serial_frame_receiver_assertions (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Link wires.
    input wire logic frameSyncN,
    input wire logic serialClk,
    input wire logic serialData
);
    logic prevClk_ff;
    logic [4:0] fallCnt_ff;

    // Counts serial clock falls inside the current frame.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prevClk_ff <= 1'b1;
            fallCnt_ff <= 5'h00;
        end else begin
            prevClk_ff <= serialClk;
            if (frameSyncN)
                fallCnt_ff <= 5'h00;
            else if (prevClk_ff && !serialClk)
                fallCnt_ff <= fallCnt_ff + 5'h01;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Setup after the frame opens, then the first fall.
    sequence setupSeq;
        serialClk [*2] ##1 !serialClk;
    endsequence

    chk_idle_clock_high: assert property (frameSyncN |-> serialClk)
        else $error("Serial clock low outside a frame.");
    chk_sync_setup: assert property ($fell(frameSyncN) |-> setupSeq)
        else $error("Frame opened without setup time.");
    chk_sample_stable: assert property ($fell(serialClk) |->
        $stable(serialData)) else $error("Data moved at a fall.");
    chk_data_moves_rise: assert property (!frameSyncN &&
        !$fell(frameSyncN) && $changed(serialData) |-> $rose(serialClk))
        else $error("Data moved away from a rise.");
    chk_low_phase: assert property ($fell(serialClk) |=>
        !serialClk || frameSyncN) else $error("Low phase too short.");
    chk_high_phase: assert property ($rose(serialClk) &&
        !frameSyncN |=> serialClk) else $error("High phase too short.");
    chk_fall_limit: assert property (fallCnt_ff <= 5'h18)
        else $error("More than a word of falls.");
    chk_stop_after_word: assert property (fallCnt_ff == 5'h18 |->
        !serialClk || frameSyncN) else $error("Clock ran past word.");
    chk_sync_gap: assert property ($rose(frameSyncN) |->
        frameSyncN [*2]) else $error("Frame sync high too short.");
    chk_end_in_low: assert property ($rose(frameSyncN) |->
        !$past(serialClk)) else $error("Frame closed in high phase.");
endmodule // dac_serial_frame_receiver_assertions

//--- verification/dac_serial_frame_receiver_tb.sv
/*
 * Self-checking bench: host end and device end joined by the link.
 * Assumes both ends share core_clk; a queue models expected words.
 */
`timescale 1ns/100ps
module dac_serial_frame_receiver_tb;
    import dac_link_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b0;
    logic txValid = 1'b0;
    logic [23:0] txData = 24'h000000;
    logic abortReq = 1'b0;
    logic cmdReady = 1'b1;
    logic clearOverrun = 1'b0;
    logic selectInternalRef = 1'b0;
    logic rndReady = 1'b0;
    logic txReady, txDone, cmdValid, frameActive, overrun, refDriveEn;
    logic syncN;
    logic [23:0] cmdWord;
    int miscompares = 0;
    int totalChecks = 0;
    int doneCnt = 0;
    int fullSent = 0;
    int seed = 32'h254d92de;
    logic [23:0] expQ[$];

    serial_link_if link();
    assign syncN = link.frameSyncN;

    dac_link_host dac_link_host_i (.core_clk(core_clk), .rst(rst),
        .link(link), .txValid(txValid), .txData(txData),
        .txReady(txReady), .abortReq(abortReq), .txDone(txDone));
    dac_serial_frame_receiver dac_serial_frame_receiver_i (
        .core_clk(core_clk), .rst(rst), .link(link),
        .cmdReady(cmdReady), .cmdWord(cmdWord), .cmdValid(cmdValid),
        .frameActive(frameActive), .overrun(overrun),
        .clearOverrun(clearOverrun), .selectInternalRef(selectInternalRef),
        .refDriveEn(refDriveEn));
    dac_serial_frame_receiver_assertions
        dac_serial_frame_receiver_assertions_i (.core_clk(core_clk),
        .rst(rst), .frameSyncN(link.frameSyncN),
        .serialClk(link.serialClk), .serialData(link.serialData));

    // Core clock, 8 ns period.
    initial forever #4 core_clk = ~core_clk;

    // Compares one value and counts the outcome.
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        totalChecks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // Level of a watched wire: 0 ready, 1 frame sync, 2 done.
    function automatic logic sigOf(input int sel);
        return (sel == 0) ? txReady : (sel == 1) ? syncN : txDone;
    endfunction

    // Waits off the edge for a watched wire to reach a level, bounded.
    task automatic waitSig(input int sel, input logic v);
        int n;
        n = 0;
        while (sigOf(sel) !== v && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (sigOf(sel) !== v)
            chk("wait", {23'h0, v}, {23'h0, sigOf(sel)});
    endtask

    // Lets n edges pass and lands just after the last.
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Sends one word; an aborted frame must leave no trace.
    task automatic send(input logic [23:0] w, input bit ab);
        waitSig(0, 1'b1);
        txValid = 1'b1;
        txData = w;
        cyc(1);
        txValid = 1'b0;
        waitSig(1, 1'b0);
        cyc(4);
        chk("frameActive", 24'h1, {23'h0, frameActive});
        if (ab) begin
            cyc(16);
            abortReq = 1'b1;
            waitSig(1, 1'b1);
            abortReq = 1'b0;
        end else begin
            fullSent++;
            if (expQ.size() < FIFO_DEPTH)
                expQ.push_back(w);
            waitSig(2, 1'b1);
        end
    endtask

    // Decoder side: counts frames and checks every handed word.
    always @(posedge core_clk) begin
        if (txDone === 1'b1)
            doneCnt++;
        if (cmdValid === 1'b1) begin
            if (expQ.size() == 0)
                chk("cmdValid", 24'h0, 24'h1);
            else
                chk("cmdWord", expQ.pop_front(), cmdWord);
        end
        if (rndReady)
            cmdReady <= #1 1'($random(seed));
    end

    // Ends the run with the counts and the verdict.
    task summarize;
        $display("Checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        repeat (30000) @(posedge core_clk);
        miscompares++;
        summarize;
    end

    // Main sequence.
    initial begin
        // Reset rises after time zero so every asynchronous reset,
        // the link-side ones included, sees an edge.
        #1;
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        chk("refDriveEn", 24'h0, {23'h0, refDriveEn});
        selectInternalRef = 1'b1;
        cyc(2);
        chk("refDriveEn", 24'h1, {23'h0, refDriveEn});
        for (int i = 0; i < 8; i++) begin
            send(i == 0 ? 24'hffffff : i == 1 ? 24'h000001 :
                24'($random(seed)), 1'b0);
        end
        cyc(20);
        chk("frameActive", 24'h0, {23'h0, frameActive});
        send(24'ha5a5a5, 1'b1);
        send(24'h5a5a5a, 1'b0);
        cyc(20);
        cmdReady = 1'b0;
        for (int i = 0; i < 33; i++) begin
            if (i == 32)
                chk("overrun", 24'h0, {23'h0, overrun});
            send(24'($random(seed)), 1'b0);
        end
        cyc(10);
        chk("overrun", 24'h1, {23'h0, overrun});
        rndReady = 1'b1;
        for (int n = 0; n < 2000 && expQ.size() != 0; n++)
            cyc(1);
        chk("queue left", 24'h0, 24'(expQ.size()));
        rndReady = 1'b0;
        cyc(1);
        cmdReady = 1'b1;
        clearOverrun = 1'b1;
        cyc(1);
        clearOverrun = 1'b0;
        cyc(1);
        chk("overrun", 24'h0, {23'h0, overrun});
        chk("txDone count", 24'(fullSent), 24'(doneCnt));
        summarize;
    end
endmodule // dac_serial_frame_receiver_tb
